// *** design/spf_pkg.sv ***
package spf_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CONTROL  = 10'h098;
    localparam logic [9:0] IDX_BUFFER   = 10'h099;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h09a;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h09b;
    localparam logic [9:0] IDX_OPTION   = 10'h09c;
    localparam logic [7:0] CONTROL_RST  = 8'h00;
    localparam logic [1:0] MASK_RST     = 2'h0;
    localparam logic [1:0] OPTION_RST   = 2'h0;
    // Option and interrupt field positions
    localparam int OPT_SINGLE_PIN = 0;
    localparam int OPT_SLOW_DIV   = 1;
    localparam int IRQ_TX         = 0;
    localparam int IRQ_RX         = 1;
    // Oversampling and fixed-rate dividers
    localparam int OS_TICKS   = 16;
    localparam int DIV_FAST   = 32 / OS_TICKS;
    localparam int DIV_SLOW   = 64 / OS_TICKS;
    localparam logic [3:0] OS_MID  = 4'(OS_TICKS / 2 - 1);
    localparam logic [3:0] OS_LAST = 4'(OS_TICKS - 1);
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_SHIFT  = 2'b00,
        MODE_ASYNC8 = 2'b01,
        MODE_FIXED9 = 2'b10,
        MODE_VAR9   = 2'b11
    } spf_mode_t;

    typedef struct packed {
        logic mode_select_hi;
        logic mode_select_lo;
        logic multiproc_filter;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } spf_ctrl_t;
endpackage

// *** design/spf_serial_port.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Mode 00 is an 8-bit shift register clocked at system clock over two.
// - Mode 01 is an 8-bit asynchronous port at the variable rate.
// - Mode 10 is a 9-bit asynchronous port at clock over 32 or 64.
// - Mode 11 is a 9-bit asynchronous port at the variable rate.
// - 9-bit modes with filter set drop frames whose ninth bit is zero.
// - 8-bit async mode with filter set completes only on a valid stop bit.
// - Reception happens only while the receive-enable bit is one.
// - 9-bit modes transmit control bit 3 as the ninth bit.
// - Bit 2 holds the received ninth bit, or stop bit in 8-bit async mode.
// - Transmit-done sets after bit eight or at stop start; software clears.
// - Receive-done sets after bit eight or at stop sample; software clears.
// - Buffer write feeds transmitter, read returns received byte (mode 00 keeps bit 7 of the previous reception); independent.
// - Single-pin option shares one pin for half-duplex transmit and receive.
module spf_serial_port #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Serial line
    input  wire logic              rate_tick,
    input  wire logic              rxd_in,
    input  wire logic              line_in,
    output logic                   line_out,
    output logic                   line_oe,
    output logic                   shift_clk,
    // Interrupt
    output logic                   irq
);
    if (ADDR_W < 12) begin : g_chk
        $error("ADDR_W must be at least 12");
    end

    typedef enum logic {T_IDLE = 1'b0, T_BUSY = 1'b1} spf_tx_st_t;
    typedef enum logic [1:0] {
        R_IDLE  = 2'b00,
        R_START = 2'b01,
        R_BITS  = 2'b10,
        R_SYNC  = 2'b11
    } spf_rx_st_t;

    spf_pkg::spf_ctrl_t ctrl_ff, nxt_ctrl;
    logic [7:0]  rxbuf_ff, nxt_rxbuf;
    logic [1:0]  stat_ff, nxt_stat, mask_ff, nxt_mask, opt_ff, nxt_opt;
    logic        bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        wr_fire, rd_fire, wr_en, buf_wr, wmap, rmap;
    logic [9:0]  widx, ridx;

    spf_tx_st_t  tx_st_ff, nxt_tx_st;
    spf_rx_st_t  rx_st_ff, nxt_rx_st;
    logic [10:0] tx_sh_ff, nxt_tx_sh;
    logic [3:0]  tx_cnt_ff, nxt_tx_cnt, tx_os_ff, nxt_tx_os;
    logic [8:0]  rx_sh_ff, nxt_rx_sh;
    logic [3:0]  rx_cnt_ff, nxt_rx_cnt, rx_os_ff, nxt_rx_os;
    logic [1:0]  div_ff, nxt_div;
    logic        prev_ff, nxt_prev;
    logic        tx_set, rx_set, os_tick, line_rx, nine, mode0, step;
    logic        tx_end, rx_ok;
    logic [3:0]  rx_last;
    spf_pkg::spf_mode_t mode;

    assign mode  = spf_pkg::spf_mode_t'({ctrl_ff.mode_select_hi,
                                         ctrl_ff.mode_select_lo});
    assign mode0 = (mode == spf_pkg::MODE_SHIFT);
    assign nine  = ctrl_ff.mode_select_hi;

    always_comb begin
        wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
        rd_fire = s_axi_arvalid && !rvalid_ff;
        widx    = s_axi_awaddr[11:2];
        ridx    = s_axi_araddr[11:2];
        wmap    = widx >= spf_pkg::IDX_CONTROL
                  && widx <= spf_pkg::IDX_OPTION;
        rmap    = ridx >= spf_pkg::IDX_CONTROL
                  && ridx <= spf_pkg::IDX_OPTION;
        wr_en   = wr_fire && s_axi_wstrb[0];
        buf_wr  = wr_en && widx == spf_pkg::IDX_BUFFER;
        nxt_ctrl  = ctrl_ff;
        nxt_rxbuf = rxbuf_ff;
        nxt_mask  = mask_ff;
        nxt_opt   = opt_ff;
        nxt_stat  = stat_ff;
        if (wr_en && widx == spf_pkg::IDX_CONTROL)
            nxt_ctrl = spf_pkg::spf_ctrl_t'(s_axi_wdata[7:0]);
        if (wr_en && widx == spf_pkg::IDX_IRQ_MASK)
            nxt_mask = s_axi_wdata[1:0];
        if (wr_en && widx == spf_pkg::IDX_OPTION)
            nxt_opt = s_axi_wdata[1:0];
        if (rd_fire && ridx == spf_pkg::IDX_IRQ_STAT)
            nxt_stat = 2'h0;
        if (tx_set) begin
            nxt_ctrl.tx_done_flag = 1'b1;
            nxt_stat[spf_pkg::IRQ_TX] = 1'b1;
        end
        if (rx_set) begin
            nxt_ctrl.rx_done_flag = 1'b1;
            nxt_stat[spf_pkg::IRQ_RX] = 1'b1;
            nxt_rxbuf = rx_sh_ff[7:0];
            if (!mode0)
                nxt_ctrl.rx_ninth_bit = nine ? rx_sh_ff[8] : line_rx;
        end
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        if (bvalid_ff && s_axi_bready)
            nxt_bvalid = 1'b0;
        if (wr_fire) begin
            nxt_bvalid = 1'b1;
            nxt_bresp  = wmap ? spf_pkg::RESP_OKAY : spf_pkg::RESP_SLVERR;
        end
        nxt_rvalid = rvalid_ff;
        nxt_rresp  = rresp_ff;
        nxt_rdata  = rdata_ff;
        if (rvalid_ff && s_axi_rready)
            nxt_rvalid = 1'b0;
        if (rd_fire) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = rmap ? spf_pkg::RESP_OKAY : spf_pkg::RESP_SLVERR;
            nxt_rdata  = 32'h0;
            unique case (ridx)
                spf_pkg::IDX_CONTROL:  nxt_rdata[7:0] = ctrl_ff;
                spf_pkg::IDX_BUFFER:   nxt_rdata[7:0] = rxbuf_ff;
                spf_pkg::IDX_IRQ_STAT: nxt_rdata[1:0] = stat_ff;
                spf_pkg::IDX_IRQ_MASK: nxt_rdata[1:0] = mask_ff;
                spf_pkg::IDX_OPTION:   nxt_rdata[1:0] = opt_ff;
                default:               nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff   <= spf_pkg::CONTROL_RST;
            rxbuf_ff  <= 8'h00;
            stat_ff   <= 2'h0;
            mask_ff   <= spf_pkg::MASK_RST;
            opt_ff    <= spf_pkg::OPTION_RST;
            bvalid_ff <= 1'b0;
            bresp_ff  <= 2'h0;
            rvalid_ff <= 1'b0;
            rresp_ff  <= 2'h0;
            rdata_ff  <= 32'h0;
        end else begin
            ctrl_ff   <= nxt_ctrl;
            rxbuf_ff  <= nxt_rxbuf;
            stat_ff   <= nxt_stat;
            mask_ff   <= nxt_mask;
            opt_ff    <= nxt_opt;
            bvalid_ff <= nxt_bvalid;
            bresp_ff  <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff  <= nxt_rresp;
            rdata_ff  <= nxt_rdata;
        end
    end

    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign s_axi_arready = rd_fire;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;
    assign irq           = |(stat_ff & mask_ff);

    always_comb begin
        line_rx = opt_ff[spf_pkg::OPT_SINGLE_PIN] ? line_in : rxd_in;
        // fixed divider to 16x sample rate
        nxt_div = div_ff + 2'h1;
        if (div_ff == (opt_ff[spf_pkg::OPT_SLOW_DIV]
                       ? 2'(spf_pkg::DIV_SLOW - 1)
                       : 2'(spf_pkg::DIV_FAST - 1)))
            nxt_div = 2'h0;
        os_tick = (mode == spf_pkg::MODE_FIXED9) ? nxt_div == 2'h0
                                                 : rate_tick;
        // whole start bit
        // Restart keeps the first bit full; a receive slips under one tick
        if (buf_wr && tx_st_ff == T_IDLE)
            nxt_div = 2'h0;
        step    = mode0 || os_tick;
        tx_end  = step && tx_os_ff == (mode0 ? 4'h1 : spf_pkg::OS_LAST);
        nxt_tx_st  = tx_st_ff;
        nxt_tx_sh  = tx_sh_ff;
        nxt_tx_cnt = tx_cnt_ff;
        nxt_tx_os  = tx_os_ff;
        tx_set     = 1'b0;
        unique case (tx_st_ff)
            T_IDLE: begin
                if (buf_wr) begin
                    nxt_tx_st = T_BUSY;
                    nxt_tx_os = 4'h0;
                    if (mode0) begin
                        nxt_tx_sh  = {3'b111, s_axi_wdata[7:0]};
                        nxt_tx_cnt = 4'd8;
                    end else if (nine) begin
                        nxt_tx_sh  = {1'b1, ctrl_ff.tx_ninth_bit,
                                      s_axi_wdata[7:0], 1'b0};
                        nxt_tx_cnt = 4'd11;
                    end else begin
                        nxt_tx_sh  = {2'b11, s_axi_wdata[7:0], 1'b0};
                        nxt_tx_cnt = 4'd10;
                    end
                end
            end
            T_BUSY: begin
                if (step)
                    nxt_tx_os = mode0 ? {3'h0, ~tx_os_ff[0]}
                                      : tx_os_ff + 4'h1;
                if (tx_end) begin
                    nxt_tx_sh  = {1'b1, tx_sh_ff[10:1]};
                    nxt_tx_cnt = tx_cnt_ff - 4'h1;
                    // after bit eight or at stop start
                    if (tx_cnt_ff == (mode0 ? 4'h1 : 4'h2))
                        tx_set = 1'b1;
                    if (tx_cnt_ff == 4'h1)
                        nxt_tx_st = T_IDLE;
                end
            end
        endcase
    end

    always_comb begin
        nxt_prev   = line_rx;
        nxt_rx_st  = rx_st_ff;
        nxt_rx_sh  = rx_sh_ff;
        nxt_rx_cnt = rx_cnt_ff;
        nxt_rx_os  = rx_os_ff;
        rx_set     = 1'b0;
        rx_last    = nine ? 4'd9 : 4'd8;
        rx_ok = !ctrl_ff.rx_done_flag
                && (!ctrl_ff.multiproc_filter
                    || (nine ? rx_sh_ff[8] : line_rx));
        unique case (rx_st_ff)
            R_IDLE: begin
                nxt_rx_cnt = 4'h0;
                nxt_rx_os  = 4'h0;
                if (ctrl_ff.rx_enable) begin
                    if (mode0 && !ctrl_ff.rx_done_flag
                        && tx_st_ff == T_IDLE)
                        nxt_rx_st = R_SYNC;
                    else if (!mode0 && prev_ff && !line_rx
                             && !(opt_ff[spf_pkg::OPT_SINGLE_PIN]
                                  && tx_st_ff == T_BUSY))
                        nxt_rx_st = R_START;
                end
            end
            R_START: begin
                if (os_tick) begin
                    nxt_rx_os = rx_os_ff + 4'h1;
                    if (rx_os_ff == spf_pkg::OS_MID) begin
                        nxt_rx_os = 4'h0;
                        nxt_rx_st = line_rx ? R_IDLE : R_BITS;
                    end
                end
            end
            R_BITS: begin
                if (os_tick) begin
                    nxt_rx_os = rx_os_ff + 4'h1;
                    if (rx_os_ff == spf_pkg::OS_LAST) begin
                        nxt_rx_cnt = rx_cnt_ff + 4'h1;
                        if (rx_cnt_ff == rx_last) begin
                            rx_set    = rx_ok;
                            nxt_rx_st = R_IDLE;
                        end else begin
                            nxt_rx_sh[rx_cnt_ff] = line_rx;
                        end
                    end
                end
            end
            R_SYNC: begin
                nxt_rx_os = {3'h0, ~rx_os_ff[0]};
                if (rx_os_ff[0]) begin
                    nxt_rx_cnt = rx_cnt_ff + 4'h1;
                    nxt_rx_sh[rx_cnt_ff] = line_rx;
                    if (rx_cnt_ff == 4'd7) begin
                        rx_set    = 1'b1;
                        nxt_rx_st = R_IDLE;
                    end
                end
            end
        endcase
        if (!ctrl_ff.rx_enable)
            nxt_rx_st = R_IDLE;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_st_ff  <= T_IDLE;
            tx_sh_ff  <= 11'h7ff;
            tx_cnt_ff <= 4'h0;
            tx_os_ff  <= 4'h0;
            rx_st_ff  <= R_IDLE;
            rx_sh_ff  <= 9'h000;
            rx_cnt_ff <= 4'h0;
            rx_os_ff  <= 4'h0;
            div_ff    <= 2'h0;
            prev_ff   <= 1'b1;
        end else begin
            tx_st_ff  <= nxt_tx_st;
            tx_sh_ff  <= nxt_tx_sh;
            tx_cnt_ff <= nxt_tx_cnt;
            tx_os_ff  <= nxt_tx_os;
            rx_st_ff  <= nxt_rx_st;
            rx_sh_ff  <= nxt_rx_sh;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_os_ff  <= nxt_rx_os;
            div_ff    <= nxt_div;
            prev_ff   <= nxt_prev;
        end
    end

    // shift clock low then high per bit
    assign shift_clk = (mode0 && tx_st_ff == T_BUSY) ? tx_os_ff[0]
                     : (rx_st_ff == R_SYNC)         ? rx_os_ff[0]
                     : 1'b1;
    assign line_out  = tx_sh_ff[0];
    assign line_oe   = !opt_ff[spf_pkg::OPT_SINGLE_PIN]
                       || tx_st_ff == T_BUSY;
endmodule // spf_serial_port

// *** testbench/spf_sva.sv ***
`timescale 1ns/1ps
module spf_sva #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // Register bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // Serial line
    input wire logic              line_out,
    input wire logic              line_oe,
    input wire logic              shift_clk
);
    logic [1:0] mode_ff, nxt_mode;
    logic       pin_ff, nxt_pin, slow_ff, nxt_slow, last_ff;
    logic [4:0] run_ff, nxt_run;
    logic       wr_ok;
    logic       sclk_ff;
    logic [2:0] fall_cnt_ff, nxt_falls;

    // Mirror of mode and option bits from taken writes
    assign wr_ok = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                   && s_axi_wstrb[0];
    always_comb begin
        nxt_mode = mode_ff;
        nxt_pin  = pin_ff;
        nxt_slow = slow_ff;
        if (wr_ok && s_axi_awaddr[11:2] == spf_pkg::IDX_CONTROL) begin
            nxt_mode = s_axi_wdata[7:6];
        end
        if (wr_ok && s_axi_awaddr[11:2] == spf_pkg::IDX_OPTION) begin
            nxt_pin  = s_axi_wdata[spf_pkg::OPT_SINGLE_PIN];
            nxt_slow = s_axi_wdata[spf_pkg::OPT_SLOW_DIV];
        end
        nxt_run = (line_out != last_ff) ? 5'h00 : run_ff + 5'h01;
        // Falls of the shift clock, eight to a frame
        nxt_falls = fall_cnt_ff + {2'b00, sclk_ff && !shift_clk};
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff <= 2'h0;
            pin_ff  <= 1'b0;
            slow_ff <= 1'b0;
            last_ff <= 1'b1;
            sclk_ff <= 1'b1;
            fall_cnt_ff <= 3'h0;
            run_ff  <= 5'h00;
        end else begin
            mode_ff <= nxt_mode;
            pin_ff  <= nxt_pin;
            slow_ff <= nxt_slow;
            last_ff <= line_out;
            sclk_ff <= shift_clk;
            fall_cnt_ff <= nxt_falls;
            run_ff  <= nxt_run;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_take;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    endsequence
    sequence s_rd_unmapped;
        s_axi_arvalid && !s_axi_rvalid
            && s_axi_araddr[11:2] > spf_pkg::IDX_OPTION;
    endsequence
    sequence s_shift_bit;
        !shift_clk ##1 shift_clk;
    endsequence

    AST_WR_OKAY: assert property (s_wr_take ##0 (s_axi_awaddr[11:2] inside
        {[spf_pkg::IDX_CONTROL:spf_pkg::IDX_OPTION]})
        |=> s_axi_bvalid && s_axi_bresp == spf_pkg::RESP_OKAY)
        else $error("write not answered okay one cycle later");
    AST_RD_SLVERR: assert property (s_rd_unmapped |=> s_axi_rvalid
        && s_axi_rresp == spf_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response held after handshake");
    AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_SHIFT_PULSE: assert property ($fell(shift_clk) |-> s_shift_bit)
        else $error("shift clock low phase not one cycle");
    AST_SHIFT_HIGH: assert property ($rose(shift_clk)
        && fall_cnt_ff != 3'h0 |=> !shift_clk)
        else $error("shift clock high phase inside frame not one cycle");
    AST_SHIFT_IDLE: assert property (mode_ff != 2'b00 |-> shift_clk)
        else $error("shift clock moves outside shift mode");
    AST_FIXED_BIT: assert property (mode_ff == 2'b10 && !slow_ff
        && $rose(line_out) |-> run_ff == 5'h1f)
        else $error("fixed rate low run not a multiple of 32 clocks");
    AST_OE_TWO_PIN: assert property (!pin_ff |-> line_oe)
        else $error("line not driven in two pin use");
endmodule // spf_sva

bind spf_serial_port spf_sva #(.ADDR_W(ADDR_W)) u_spf_sva (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .line_out, .line_oe, .shift_clk
);

// *** testbench/spf_node.sv ***
`timescale 1ns/1ps
module spf_node #(
    parameter int BIT_CLKS = 32
) (
    // Clock
    input wire logic aclk,
    // Line toward the port
    output logic     rxd
);
    initial rxd = 1'b1;

    // start, data LSB first, ninth, stop
    task automatic send(input logic [8:0] d, input int nb, input logic stop);
        for (int i = 0; i < nb + 2; i++) begin
            @(posedge aclk);
            rxd <= (i == 0) ? 1'b0 : (i > nb) ? stop : d[i-1];
            repeat (BIT_CLKS - 1) @(posedge aclk);
        end
        @(posedge aclk);
        rxd <= 1'b1;
    endtask
endmodule // spf_node

// *** testbench/spf_serial_port_tb.sv ***
`timescale 1ns/1ps
module spf_serial_port_tb;
    logic        aclk, aresetn;
    logic        rate_tick = 1'b0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        line_out, line_oe, shift_clk, irq;
    wire         rxd_in, line_in;
    int          n_fail, tests_run, k;

    assign line_in = line_oe ? line_out : rxd_in;
    spf_serial_port u_spf_serial_port (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rate_tick,
        .rxd_in, .line_in, .line_out, .line_oe, .shift_clk, .irq);
    spf_node u_spf_node (.aclk(aclk), .rxd(rxd_in));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) rate_tick <= ~rate_tick;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [9:0] i, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr  <= {i, 2'b00};
        s_axi_wdata   <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        @(posedge aclk);
        while (s_axi_awready !== 1'b1) @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        @(posedge aclk);
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] i);
        @(posedge aclk);
        s_axi_araddr  <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [9:0] i, input logic [7:0] e);
        rd(i);
        chk(n, {24'h0, e}, d);
    endtask
    // Samples each bit mid-way, stop bit last
    task automatic tx_chk(input logic [8:0] v, input int nb);
        k = 0;
        while (line_out !== 1'b0 && k < 200) begin
            @(posedge aclk);
            k++;
        end
        repeat (16) @(posedge aclk);
        chk("start bit", 32'h0, 32'(line_out));
        for (int i = 0; i <= nb; i++) begin
            repeat (32) @(posedge aclk);
            chk("line bit", (i == nb) ? 32'h1 : 32'(v[i]), 32'(line_out));
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge aclk);
        n_fail++;
        $display("BAD watchdog expected finish seen timeout");
        end_of_test();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid} = 3'h0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("control", spf_pkg::IDX_CONTROL, 8'h00);
        rchk("mask", spf_pkg::IDX_IRQ_MASK, 8'h00);
        rd(10'h0a0);
        chk("unmapped resp", 32'(spf_pkg::RESP_SLVERR), 32'(r));
        $display("test reset done");
        wr(spf_pkg::IDX_IRQ_MASK, 8'h03);
        for (int m = 1; m < 4; m++) begin
            wr(spf_pkg::IDX_CONTROL, {m[1:0], 2'b00, m[0], 3'b000});
            wr(spf_pkg::IDX_BUFFER, 8'(8'h5a + m));
            tx_chk({m[0], 8'(8'h5a + m)}, m[1] ? 9 : 8);
            chk("irq", 32'h1, 32'(irq));
            rchk("control", spf_pkg::IDX_CONTROL, {m[1:0], 2'b00, m[0], 3'b010});
            rchk("status", spf_pkg::IDX_IRQ_STAT, 8'h01);
            rchk("status", spf_pkg::IDX_IRQ_STAT, 8'h00);
            repeat (20) @(posedge aclk);
        end
        $display("test transmit done");
        wr(spf_pkg::IDX_CONTROL, 8'hb0);
        u_spf_node.send(9'h03c, 9, 1'b1);
        rchk("control", spf_pkg::IDX_CONTROL, 8'hb0);
        u_spf_node.send(9'h1c3, 9, 1'b1);
        rchk("control", spf_pkg::IDX_CONTROL, 8'hb5);
        wr(spf_pkg::IDX_BUFFER, 8'h11);
        tx_chk(9'h011, 9);
        rchk("buffer", spf_pkg::IDX_BUFFER, 8'hc3);
        rchk("status", spf_pkg::IDX_IRQ_STAT, 8'h03);
        repeat (20) @(posedge aclk);
        $display("test filter done");
        wr(spf_pkg::IDX_CONTROL, 8'h60);
        u_spf_node.send(9'h069, 8, 1'b1);
        rchk("control", spf_pkg::IDX_CONTROL, 8'h60);
        wr(spf_pkg::IDX_CONTROL, 8'h70);
        u_spf_node.send(9'h096, 8, 1'b0);
        rchk("control", spf_pkg::IDX_CONTROL, 8'h70);
        u_spf_node.send(9'h069, 8, 1'b1);
        rchk("control", spf_pkg::IDX_CONTROL, 8'h75);
        rchk("buffer", spf_pkg::IDX_BUFFER, 8'h69);
        $display("test receive done");
        wr(spf_pkg::IDX_OPTION, 8'h01);
        rchk("option", spf_pkg::IDX_OPTION, 8'h01);
        wr(spf_pkg::IDX_CONTROL, 8'hd0);
        chk("oe idle", 32'h0, 32'(line_oe));
        wr(spf_pkg::IDX_BUFFER, 8'h3e);
        chk("oe busy", 32'h1, 32'(line_oe));
        tx_chk(9'h03e, 9);
        repeat (20) @(posedge aclk);
        u_spf_node.send(9'h1a7, 9, 1'b1);
        rchk("control", spf_pkg::IDX_CONTROL, 8'hd7);
        rchk("buffer", spf_pkg::IDX_BUFFER, 8'ha7);
        $display("test single pin done");
        wr(spf_pkg::IDX_OPTION, 8'h00);
        wr(spf_pkg::IDX_CONTROL, 8'h00);
        wr(spf_pkg::IDX_BUFFER, 8'hb4);
        for (int i = 0; i < 8; i++) begin
            k = 0;
            while (shift_clk !== 1'b0 && k < 50) begin
                @(posedge aclk);
                k++;
            end
            chk("shift bit", 32'((8'hb4 >> i) & 8'h01), 32'(line_out));
            @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
        rchk("control", spf_pkg::IDX_CONTROL, 8'h02);
        $display("test shift done");
        wr(spf_pkg::IDX_CONTROL, 8'h10);
        repeat (20) @(posedge aclk);
        rchk("control", spf_pkg::IDX_CONTROL, 8'h11);
        rchk("buffer", spf_pkg::IDX_BUFFER, 8'hff);
        $display("test shift receive done");
        end_of_test();
    end
endmodule // spf_serial_port_tb
